// [hdl/ddc_pkg.sv]
package ddc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CODE_W = 8;
    localparam int NCH = 2;
    localparam int CTRL_W = 4;
    localparam int CTRL_BITS_PER_CH = 2;
    localparam int CTRL_EN_OFS = 0;
    localparam int CTRL_MD_OFS = 1;
    localparam int STAT_VALID_LSB = 0;
    localparam int STAT_ACTIVE_LSB = 2;
    localparam int LEVEL_CH_STRIDE = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CODE0 = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CODE1 = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_LEVEL = 8'h10;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
    localparam logic [CODE_W-1:0] CODE_RST = 8'h00;
    localparam logic [CODE_W-1:0] LEVEL_IDLE = 8'h00;

    typedef enum logic [1:0] {
        CH_OFF,
        CH_WAIT,
        CH_LIVE
    } ddc_ch_state_t;
endpackage

// [hdl/ddc_channel.sv]
`timescale 1ns/100ps
module ddc_channel (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic rt_mode,
    input wire logic code_wr,
    input wire logic [ddc_pkg::CODE_W-1:0] code_wdata,
    input wire logic [ddc_pkg::CODE_W-1:0] code_held,
    input wire logic trigger,
    output logic [ddc_pkg::CODE_W-1:0] level_q,
    output logic active_q,
    output logic valid_q
);
    ddc_pkg::ddc_ch_state_t state_q, state_d;
    logic [ddc_pkg::CODE_W-1:0] level_d;
    logic active_d;
    logic valid_d;

    always_comb begin
        state_d = state_q;
        level_d = level_q;
        active_d = enable;
        valid_d = valid_q;
        case (state_q)
            ddc_pkg::CH_OFF: begin
                if (enable && rt_mode) begin
                    // level stays meaningless until the first trigger
                    state_d = ddc_pkg::CH_WAIT;
                    valid_d = 1'b0;
                end else if (enable) begin
                    state_d = ddc_pkg::CH_LIVE;
                    level_d = code_held;
                    valid_d = 1'b1;
                end
            end
            ddc_pkg::CH_WAIT: begin
                if (!enable) begin
                    state_d = ddc_pkg::CH_OFF;
                end else if (!rt_mode) begin
                    state_d = ddc_pkg::CH_LIVE;
                    level_d = code_held;
                    valid_d = 1'b1;
                end else if (trigger) begin
                    state_d = ddc_pkg::CH_LIVE;
                    level_d = code_held;
                    valid_d = 1'b1;
                end
            end
            ddc_pkg::CH_LIVE: begin
                if (!enable) begin
                    state_d = ddc_pkg::CH_OFF;
                end else if (rt_mode) begin
                    // a write alone never moves the output here
                    if (trigger) begin
                        level_d = code_held;
                    end
                end else if (code_wr) begin
                    level_d = code_wdata;
                end
            end
            default: begin
                state_d = ddc_pkg::CH_OFF;
            end
        endcase
        if (state_d == ddc_pkg::CH_OFF) begin
            level_d = ddc_pkg::LEVEL_IDLE;
            valid_d = 1'b0;
            active_d = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ddc_pkg::CH_OFF;
            level_q <= ddc_pkg::LEVEL_IDLE;
            active_q <= 1'b0;
            valid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            level_q <= level_d;
            active_q <= active_d;
            valid_q <= valid_d;
        end
    end
endmodule // ddc_channel

// [hdl/ddc_top.sv]
// Contract
// - two independent channels each drive an 8-bit code m (0..255) giving m/256 of full scale.
// - the mode/enable control register resets to zero and takes byte or single-bit accesses.
// - each code register resets to zero and is read and written as a byte.
// - in normal mode a code write converts at once and the new code drives the output.
// - in normal mode setting the enable bit drives the output with the held code.
// - in normal mode the output holds the last converted code until the next code write.
// - in real-time mode the output moves only on a timer trigger, never on a code write.
// - in real-time mode the output is undefined from enabling until the first trigger.
// - in real-time mode each trigger copies the held code to the output; the code drops a trigger in the first enabled cycle, while still in CH_OFF.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module ddc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ddc_pkg::ADDR_W-1:0] paddr,
    input wire logic [ddc_pkg::DATA_W-1:0] pwdata,
    output logic [ddc_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer0_trigger_pulse,
    input wire logic timer1_trigger_pulse,
    output logic [ddc_pkg::CODE_W-1:0] analog_output_pin0,
    output logic [ddc_pkg::CODE_W-1:0] analog_output_pin1,
    output logic ladder0_active,
    output logic ladder1_active,
    output logic level0_valid,
    output logic level1_valid
);
    logic [ddc_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [ddc_pkg::CODE_W-1:0] code_q [ddc_pkg::NCH];
    logic [ddc_pkg::CODE_W-1:0] code_d [ddc_pkg::NCH];
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic [ddc_pkg::DATA_W-1:0] prdata_q, prdata_d;
    logic access;
    logic wr_ctrl;
    logic [ddc_pkg::NCH-1:0] code_wr;
    logic [ddc_pkg::NCH-1:0] en;
    logic [ddc_pkg::NCH-1:0] md;
    logic [ddc_pkg::NCH-1:0] trig;
    logic [ddc_pkg::NCH-1:0] active;
    logic [ddc_pkg::NCH-1:0] valid;
    logic [ddc_pkg::CODE_W-1:0] level [ddc_pkg::NCH];
    logic mapped;

    // the access phase completes on the edge where pready_q is seen high
    assign access = psel && penable && pready_q;
    assign wr_ctrl = access && pwrite && (paddr == ddc_pkg::OFS_CTRL);
    assign code_wr[0] = access && pwrite && (paddr == ddc_pkg::OFS_CODE0);
    assign code_wr[1] = access && pwrite && (paddr == ddc_pkg::OFS_CODE1);
    // on-chip timers share pclk, so their pulses need no synchroniser
    assign trig[0] = timer0_trigger_pulse;
    assign trig[1] = timer1_trigger_pulse;

    genvar g;
    generate
        for (g = 0; g < ddc_pkg::NCH; g++) begin : g_ch
            localparam int EB = g * ddc_pkg::CTRL_BITS_PER_CH + ddc_pkg::CTRL_EN_OFS;
            localparam int MB = g * ddc_pkg::CTRL_BITS_PER_CH + ddc_pkg::CTRL_MD_OFS;
            assign en[g] = ctrl_q[EB];
            assign md[g] = ctrl_q[MB];
            ddc_channel u_ch (
                .pclk(pclk),
                .presetn(presetn),
                .enable(en[g]),
                .rt_mode(md[g]),
                .code_wr(code_wr[g]),
                .code_wdata(pwdata[ddc_pkg::CODE_W-1:0]),
                .code_held(code_q[g]),
                .trigger(trig[g]),
                .level_q(level[g]),
                .active_q(active[g]),
                .valid_q(valid[g])
            );
        end
    endgenerate

    always_comb begin
        mapped = 1'b1;
        case (paddr)
            ddc_pkg::OFS_CTRL,
            ddc_pkg::OFS_CODE0,
            ddc_pkg::OFS_CODE1,
            ddc_pkg::OFS_STATUS,
            ddc_pkg::OFS_LEVEL: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // one wait state: read data is registered, so pready follows it
    always_comb begin
        pready_d = psel && penable && !pready_q;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        if (pready_d) begin
            pslverr_d = !mapped;
            prdata_d = '0;
            case (paddr)
                ddc_pkg::OFS_CTRL: begin
                    prdata_d[ddc_pkg::CTRL_W-1:0] = ctrl_q;
                end
                ddc_pkg::OFS_CODE0: begin
                    prdata_d[ddc_pkg::CODE_W-1:0] = code_q[0];
                end
                ddc_pkg::OFS_CODE1: begin
                    prdata_d[ddc_pkg::CODE_W-1:0] = code_q[1];
                end
                ddc_pkg::OFS_STATUS: begin
                    prdata_d[ddc_pkg::STAT_VALID_LSB +: ddc_pkg::NCH] = valid;
                    prdata_d[ddc_pkg::STAT_ACTIVE_LSB +: ddc_pkg::NCH] = active;
                end
                ddc_pkg::OFS_LEVEL: begin
                    for (int i = 0; i < ddc_pkg::NCH; i++) begin
                        prdata_d[i*ddc_pkg::LEVEL_CH_STRIDE +: ddc_pkg::CODE_W] = level[i];
                    end
                end
                default: begin
                    prdata_d = '0;
                end
            endcase
        end
    end

    // bit accesses arrive as read-modify-write of the whole byte
    always_comb begin
        ctrl_d = ctrl_q;
        code_d = code_q;
        if (wr_ctrl) begin
            ctrl_d = pwdata[ddc_pkg::CTRL_W-1:0];
        end
        for (int i = 0; i < ddc_pkg::NCH; i++) begin
            if (code_wr[i]) begin
                code_d[i] = pwdata[ddc_pkg::CODE_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= ddc_pkg::CTRL_RST;
            code_q[0] <= ddc_pkg::CODE_RST;
            code_q[1] <= ddc_pkg::CODE_RST;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            code_q <= code_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign analog_output_pin0 = level[0];
    assign analog_output_pin1 = level[1];
    assign ladder0_active = active[0];
    assign ladder1_active = active[1];
    assign level0_valid = valid[0];
    assign level1_valid = valid[1];

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_apb_wait;
        psel && penable && !pready_q |=> pready_q ##1 !pready_q;
    endproperty
    a_apb_wait: assert property (p_apb_wait)
        else $error("pready did not pulse once after one wait state");

    property p_ctrl_read;
        pready_q && !pwrite && paddr == ddc_pkg::OFS_CTRL && psel
            |-> prdata_q[ddc_pkg::DATA_W-1:ddc_pkg::CTRL_W] == '0
                && prdata_q[ddc_pkg::CTRL_W-1:0] == ctrl_q;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("control readback wrong or upper bits not zero");

    property p_ctrl_write;
        wr_ctrl |=> ctrl_q == $past(pwdata[ddc_pkg::CTRL_W-1:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("control write not stored");

    property p_unmapped;
        psel && penable && !pready_q && !mapped |=> pslverr_q && prdata_q == '0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not answered with error");

    property p_err_with_ready;
        pslverr_q |-> pready_q;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready)
        else $error("pslverr raised outside the ready cycle");

    property p_idle_ready;
        !psel |=> !pready_q;
    endproperty
    a_idle_ready: assert property (p_idle_ready)
        else $error("pready raised without a selected access");

    property p_ready_one;
        pready_q |=> !pready_q;
    endproperty
    a_ready_one: assert property (p_ready_one)
        else $error("pready stayed high for two cycles");

    // read data must not move between accesses
    property p_rdata_hold;
        !pready_q |-> $stable(prdata_q);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed outside an access");

    property p_bad_write;
        access && pwrite && !mapped
            |=> $stable(ctrl_q) && $stable(code_q[0]) && $stable(code_q[1]);
    endproperty
    a_bad_write: assert property (p_bad_write)
        else $error("unmapped write changed a register");

    property p_code0_read;
        pready_q && psel && !pwrite && paddr == ddc_pkg::OFS_CODE0
            |-> prdata_q == {{(ddc_pkg::DATA_W-ddc_pkg::CODE_W){1'b0}}, code_q[0]};
    endproperty
    a_code0_read: assert property (p_code0_read)
        else $error("channel 0 code readback wrong");

    property p_code1_read;
        pready_q && psel && !pwrite && paddr == ddc_pkg::OFS_CODE1
            |-> prdata_q == {{(ddc_pkg::DATA_W-ddc_pkg::CODE_W){1'b0}}, code_q[1]};
    endproperty
    a_code1_read: assert property (p_code1_read)
        else $error("channel 1 code readback wrong");

    property p_status_read;
        pready_q && psel && !pwrite && paddr == ddc_pkg::OFS_STATUS
            |-> prdata_q[ddc_pkg::STAT_VALID_LSB +: ddc_pkg::NCH] == $past(valid)
                && prdata_q[ddc_pkg::STAT_ACTIVE_LSB +: ddc_pkg::NCH] == $past(active);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status readback wrong");

    generate
        for (g = 0; g < ddc_pkg::NCH; g++) begin : g_chk
            property p_code_store;
                code_wr[g] |=> code_q[g] == $past(pwdata[ddc_pkg::CODE_W-1:0]);
            endproperty
            a_code_store: assert property (p_code_store)
                else $error("code write not stored");

            property p_norm_write;
                code_wr[g] && en[g] && !md[g] && $past(en[g]) && $past(!md[g])
                    |=> level[g] == $past(pwdata[ddc_pkg::CODE_W-1:0]);
            endproperty
            a_norm_write: assert property (p_norm_write)
                else $error("normal mode write did not reach the output");

            property p_norm_enable;
                $rose(en[g]) && !md[g] |=> level[g] == $past(code_q[g]) && valid[g];
            endproperty
            a_norm_enable: assert property (p_norm_enable)
                else $error("enable in normal mode did not drive held code");

            property p_norm_hold;
                en[g] && !md[g] && $past(en[g]) && $past(!md[g]) && !code_wr[g]
                    |=> $stable(level[g]);
            endproperty
            a_norm_hold: assert property (p_norm_hold)
                else $error("normal mode output moved without a write");

            property p_rt_quiet;
                en[g] && md[g] && !trig[g] |=> $stable(level[g]);
            endproperty
            a_rt_quiet: assert property (p_rt_quiet)
                else $error("real-time output moved without a trigger");

            property p_rt_undef;
                $rose(en[g]) && md[g] && !$past(en[g]) |=> !valid[g];
            endproperty
            a_rt_undef: assert property (p_rt_undef)
                else $error("real-time level marked valid before a trigger");

            property p_rt_trig;
                en[g] && md[g] && trig[g] && $past(en[g])
                    |=> level[g] == $past(code_q[g]) && valid[g];
            endproperty
            a_rt_trig: assert property (p_rt_trig)
                else $error("trigger did not copy held code to output");

            property p_off;
                !en[g] |=> !active[g] && !valid[g] && level[g] == ddc_pkg::LEVEL_IDLE;
            endproperty
            a_off: assert property (p_off)
                else $error("disabled channel still active");

            property p_on;
                en[g] ##1 en[g] |-> active[g];
            endproperty
            a_on: assert property (p_on)
                else $error("enabled channel ladder not active");

            property p_level_read;
                pready_q && psel && !pwrite && paddr == ddc_pkg::OFS_LEVEL
                    |-> prdata_q[g*ddc_pkg::LEVEL_CH_STRIDE +: ddc_pkg::CODE_W]
                        == $past(level[g]);
            endproperty
            a_level_read: assert property (p_level_read)
                else $error("level readback wrong");

            property p_norm_valid;
                $past(en[g]) && !$past(md[g]) |-> valid[g];
            endproperty
            a_norm_valid: assert property (p_norm_valid)
                else $error("normal mode level not marked valid");

            property p_rt_wait;
                en[g] && md[g] && !valid[g] && !trig[g] |=> !valid[g] && $stable(level[g]);
            endproperty
            a_rt_wait: assert property (p_rt_wait)
                else $error("real-time level changed before the first trigger");

            c_rt_update: cover property (en[g] && md[g] && trig[g] ##1 valid[g]);
            c_norm_update: cover property (code_wr[g] && en[g] && !md[g]);
        end
    endgenerate

    c_unmapped: cover property (pslverr_q);
    c_level_read: cover property (pready_q && psel && paddr == ddc_pkg::OFS_LEVEL);
endmodule // ddc_top

// [testbench/ddc_timer_model.sv]
`timescale 1ns/100ps
module ddc_timer_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fire0,
    input wire logic fire1,
    output logic timer0_trigger_pulse,
    output logic timer1_trigger_pulse
);
    logic [1:0] fire_q;
    logic [1:0] fire_d;
    logic [1:0] pulse_q;
    logic [1:0] pulse_d;

    // a request held longer still gives a single one-cycle strobe, as a timer interrupt does
    always_comb begin
        fire_d = {fire1, fire0};
        pulse_d = {fire1, fire0} & ~fire_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fire_q <= 2'h0;
            pulse_q <= 2'h0;
        end else begin
            fire_q <= fire_d;
            pulse_q <= pulse_d;
        end
    end

    assign timer0_trigger_pulse = pulse_q[0];
    assign timer1_trigger_pulse = pulse_q[1];
endmodule // ddc_timer_model

// [testbench/dual_dac_control_test.sv]
`timescale 1ns/100ps
module dual_dac_control_test;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ddc_pkg::ADDR_W-1:0] paddr;
    logic [ddc_pkg::DATA_W-1:0] pwdata;
    logic [ddc_pkg::DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic trg0;
    logic trg1;
    logic fire0;
    logic fire1;
    logic [7:0] pin0;
    logic [7:0] pin1;
    logic act0;
    logic act1;
    logic val0;
    logic val1;
    logic [31:0] rd;
    logic err;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;

    ddc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer0_trigger_pulse(trg0),
        .timer1_trigger_pulse(trg1),
        .analog_output_pin0(pin0), // both pins only observed as outputs
        .analog_output_pin1(pin1), .ladder0_active(act0), .ladder1_active(act1),
        .level0_valid(val0), .level1_valid(val1));

    ddc_timer_model i_timer (.pclk(pclk), .presetn(presetn), .fire0(fire0),
        .fire1(fire1), .timer0_trigger_pulse(trg0), .timer1_trigger_pulse(trg1));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // the whole run needs about 120 cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares = miscompares + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // the request stays put until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        // one wait state: pready is seen on the second access edge
        chk(n, 32'h2);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic pins(input logic [7:0] e0, input logic [7:0] e1);
        @(posedge pclk);
        #1;
        chk({16'h0, pin1, pin0}, {16'h0, e1, e0});
    endtask

    task automatic fire(input logic ch);
        @(posedge pclk);
        fire0 <= !ch;
        fire1 <= ch;
        @(posedge pclk);
        fire0 <= 1'b0;
        fire1 <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fire0 = 1'b0;
        fire1 = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk({12'h0, act1, act0, val1, val0, pin1, pin0}, 32'h0);
        rdchk(ddc_pkg::OFS_CTRL, 32'h0);
        rdchk(ddc_pkg::OFS_CODE0, 32'h0);
        rdchk(ddc_pkg::OFS_CODE1, 32'h0);
        $display("test reset done");
        wr(ddc_pkg::OFS_CTRL, 32'h000000F0);
        rdchk(ddc_pkg::OFS_CTRL, 32'h0);
        wr(ddc_pkg::OFS_CODE0, 32'h000001A5);
        rdchk(ddc_pkg::OFS_CODE0, 32'h000000A5);
        pins(8'h00, 8'h00);
        wr(ddc_pkg::OFS_CTRL, 32'h00000001);
        pins(8'hA5, 8'h00);
        chk({31'h0, act0}, 32'h1);
        chk({31'h0, val0}, 32'h1);
        wr(ddc_pkg::OFS_CODE0, 32'h000000FF);
        #1;
        chk({24'h0, pin0}, 32'hFF);
        fire(1'b0);
        pins(8'hFF, 8'h00);
        $display("test normal mode done");
        wr(ddc_pkg::OFS_CODE1, 32'h0000003C);
        wr(ddc_pkg::OFS_CTRL, 32'h0000000D);
        rdchk(ddc_pkg::OFS_CTRL, 32'h0000000D);
        chk({30'h0, act1, val1}, 32'h2);
        rdchk(ddc_pkg::OFS_STATUS, 32'h0000000D);
        wr(ddc_pkg::OFS_CODE1, 32'h0000005A);
        pins(8'hFF, 8'h00);
        fire(1'b0);
        pins(8'hFF, 8'h00);
        fire(1'b1);
        pins(8'hFF, 8'h5A);
        chk({31'h0, val1}, 32'h1);
        wr(ddc_pkg::OFS_CODE1, 32'h00000081);
        fire(1'b1);
        pins(8'hFF, 8'h81);
        rdchk(ddc_pkg::OFS_LEVEL, 32'h000081FF);
        $display("test real-time mode done");
        wr(8'h20, 32'h000000FF);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        $display("test unmapped access done");
        wr(ddc_pkg::OFS_CTRL, 32'h0);
        wr(ddc_pkg::OFS_CTRL, 32'h0000000C);
        wr(ddc_pkg::OFS_CTRL, 32'h00000004);
        pins(8'h00, 8'h81);
        wr(ddc_pkg::OFS_CTRL, 32'h0);
        pins(8'h00, 8'h00);
        chk({30'h0, act1, act0}, 32'h0);
        $display("test disable done");
        give_verdict();
    end
endmodule // dual_dac_control_test
